// ===== hw/cmr_pkg.sv
package cmr_pkg;
	// Instruction word and operand layout
	localparam int INSTR_W = 14;
	localparam int FADDR_W = 7;
	localparam int LIT_W = 8;
	localparam int PC_W = 13;

	// Match patterns: a word matches when (word & mask) == value.
	// Masks leave the don't-care positions out of the match.
	localparam logic [13:0] STORE_MASK = 14'h3F80;
	localparam logic [13:0] STORE_VAL = 14'h0080;
	localparam logic [13:0] NOP_MASK = 14'h3F9F;
	localparam logic [13:0] NOP_VAL = 14'h0000;
	localparam logic [13:0] RFI_MASK = 14'h3FFF;
	localparam logic [13:0] RFI_VAL = 14'h0009;
	localparam logic [13:0] LIT_MASK = 14'h3C00;
	localparam logic [13:0] LOADLIT_VAL = 14'h3000;
	localparam logic [13:0] RETLIT_VAL = 14'h3400;

	// Global interrupt enable position in the interrupt control register
	localparam int GIE_BIT = 7;
	localparam logic [7:0] GIE_SET_MASK = 8'h80;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;

	// Decoded operations
	typedef enum logic [2:0] {
		CMR_OP_NOP,
		CMR_OP_STORE,
		CMR_OP_LOADLIT,
		CMR_OP_RFI,
		CMR_OP_RETLIT,
		CMR_OP_OTHER
	} cmr_op_t;

	// Execution states
	typedef enum logic {
		CMR_ST_EXEC,
		CMR_ST_FLUSH
	} cmr_state_t;
endpackage

// ===== hw/cmr_decode.sv
`timescale 1ns/1ps
// Combinational decoder for the move, no-op and return group
module cmr_decode (
	input wire logic [13:0] i_instr,
	output cmr_pkg::cmr_op_t o_op,
	output logic [7:0] o_literal,
	output logic [6:0] o_faddr
);
	// Pattern test shared by every opcode
	function automatic logic hit(input logic [13:0] w,
			input logic [13:0] m, input logic [13:0] v);
		hit = (w & m) == v;
	endfunction

	// Don't-care bits are masked out, so any filler decodes alike
	always_comb begin
		if (hit(i_instr, cmr_pkg::STORE_MASK, cmr_pkg::STORE_VAL)) begin
			o_op = cmr_pkg::CMR_OP_STORE;
		end else if (hit(i_instr, cmr_pkg::RFI_MASK, cmr_pkg::RFI_VAL)) begin
			o_op = cmr_pkg::CMR_OP_RFI;
		end else if (hit(i_instr, cmr_pkg::NOP_MASK, cmr_pkg::NOP_VAL)) begin
			o_op = cmr_pkg::CMR_OP_NOP;
		end else if (hit(i_instr, cmr_pkg::LIT_MASK,
				cmr_pkg::LOADLIT_VAL)) begin
			o_op = cmr_pkg::CMR_OP_LOADLIT;
		end else if (hit(i_instr, cmr_pkg::LIT_MASK,
				cmr_pkg::RETLIT_VAL)) begin
			o_op = cmr_pkg::CMR_OP_RETLIT;
		end else begin
			o_op = cmr_pkg::CMR_OP_OTHER;
		end
	end

	// Operand fields sit in the low bits
	assign o_literal = i_instr[7:0];
	assign o_faddr = i_instr[6:0];
endmodule

// ===== hw/cmr_core.sv
`timescale 1ns/1ps
module cmr_core #(
	parameter int PC_W = cmr_pkg::PC_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [13:0] i_instr,
	input wire logic i_instr_valid,
	output logic o_ready,
	input wire logic [PC_W-1:0] i_top_of_stack,
	output logic o_stack_pop,
	output logic [PC_W-1:0] o_pc,
	output logic [7:0] o_acc,
	output logic o_file_we,
	output logic [6:0] o_file_addr,
	output logic [7:0] o_file_wdata,
	output logic o_irq_ctrl_set,
	output logic [7:0] o_irq_ctrl_mask,
	output logic o_unsupported
);
	// Counter must hold at least the documented program space; the check only bounds PC_W to 1..16
	if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
		$error("cmr_core: PC_W out of range");
	end

	typedef struct packed {
		cmr_pkg::cmr_state_t state;
		logic [PC_W-1:0] pc;
		logic [7:0] acc;
		logic pop;
		logic file_we;
		logic [6:0] file_addr;
		logic [7:0] file_wdata;
		logic gie_set;
		logic unsupported;
	} cmr_core_t;

	cmr_core_t r;
	cmr_core_t next_r;
	cmr_pkg::cmr_op_t dec_op;
	logic [7:0] dec_lit;
	logic [6:0] dec_faddr;
	logic take;

	cmr_decode u_dec (
		.i_instr(i_instr),
		.o_op(dec_op),
		.o_literal(dec_lit),
		.o_faddr(dec_faddr)
	);

	// Second cycle of a return is a dead slot while the fetch refills
	assign o_ready = (r.state == cmr_pkg::CMR_ST_EXEC);
	assign take = o_ready && i_instr_valid;

	// Next-state logic; no status flag is ever written by this group
	always_comb begin
		next_r = r;
		next_r.pop = 1'b0;
		next_r.file_we = 1'b0;
		next_r.gie_set = 1'b0;
		next_r.unsupported = 1'b0;
		if (r.state == cmr_pkg::CMR_ST_FLUSH) begin
			next_r.state = cmr_pkg::CMR_ST_EXEC;
		end else if (take) begin
			unique case (dec_op)
				cmr_pkg::CMR_OP_STORE: begin
					next_r.file_we = 1'b1;
					next_r.file_addr = dec_faddr;
					next_r.file_wdata = r.acc;
					next_r.pc = r.pc + 1'b1;
				end
				cmr_pkg::CMR_OP_LOADLIT: begin
					next_r.acc = dec_lit;
					next_r.pc = r.pc + 1'b1;
				end
				cmr_pkg::CMR_OP_NOP: begin
					next_r.pc = r.pc + 1'b1;
				end
				cmr_pkg::CMR_OP_RFI: begin
					next_r.pc = i_top_of_stack;
					next_r.pop = 1'b1;
					next_r.gie_set = 1'b1;
					next_r.state = cmr_pkg::CMR_ST_FLUSH;
				end
				cmr_pkg::CMR_OP_RETLIT: begin
					next_r.acc = dec_lit;
					next_r.pc = i_top_of_stack;
					next_r.pop = 1'b1;
					next_r.state = cmr_pkg::CMR_ST_FLUSH;
				end
				cmr_pkg::CMR_OP_OTHER: begin
					// Belongs to another execution unit; flag and step on
					next_r.unsupported = 1'b1;
					next_r.pc = r.pc + 1'b1;
				end
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '{state: cmr_pkg::CMR_ST_EXEC, pc: PC_W'(cmr_pkg::PC_RST),
				acc: cmr_pkg::ACC_RST, pop: 1'b0, file_we: 1'b0,
				file_addr: 7'h00, file_wdata: 8'h00, gie_set: 1'b0,
				unsupported: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs come straight from the state register
	assign o_pc = r.pc;
	assign o_acc = r.acc;
	assign o_stack_pop = r.pop;
	assign o_file_we = r.file_we;
	assign o_file_addr = r.file_addr;
	assign o_file_wdata = r.file_wdata;
	assign o_irq_ctrl_set = r.gie_set;
	// Only the enable bit is touched; other bits keep their value
	assign o_irq_ctrl_mask = r.gie_set ? cmr_pkg::GIE_SET_MASK : 8'h00;
	assign o_unsupported = r.unsupported;

	// Checks kept beside the logic
	sequence s_flush_then_ready;
		!o_ready ##1 o_ready;
	endsequence

	sequence s_single_step;
		o_ready && (o_pc == PC_W'($past(o_pc) + 1'b1)) && !o_stack_pop;
	endsequence

	property p_store;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_STORE |=>
			(o_file_we && o_file_addr == $past(i_instr[6:0]) &&
			o_file_wdata == $past(o_acc) && o_acc == $past(o_acc)) and
			s_single_step;
	endproperty
	a_store: assert property (p_store)
		else $error("store did not copy accumulator");

	property p_loadlit;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_LOADLIT |=>
			(o_acc == $past(i_instr[7:0]) && !o_file_we) and s_single_step;
	endproperty
	a_loadlit: assert property (p_loadlit)
		else $error("load literal wrong");

	property p_dontcare;
		@(posedge i_clk) disable iff (i_rst)
		take && i_instr[13:10] == 4'hC |=>
			o_acc == $past(i_instr[7:0]) && !o_unsupported;
	endproperty
	a_dontcare: assert property (p_dontcare)
		else $error("filler bits changed load literal decode");

	property p_rfi;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_RFI |=>
			o_pc == $past(i_top_of_stack) && o_stack_pop &&
			o_acc == $past(o_acc) ##0 s_flush_then_ready;
	endproperty
	a_rfi: assert property (p_rfi)
		else $error("return from interrupt wrong");

	// The enable must really be raised, not merely never raised wrongly
	property p_rfi_gie;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_RFI |=>
			o_irq_ctrl_set && o_irq_ctrl_mask == cmr_pkg::GIE_SET_MASK;
	endproperty
	a_rfi_gie: assert property (p_rfi_gie)
		else $error("return from interrupt left global enable alone");

	property p_gie;
		@(posedge i_clk) disable iff (i_rst)
		o_irq_ctrl_set |-> o_irq_ctrl_mask[cmr_pkg::GIE_BIT] &&
			$past(take && dec_op == cmr_pkg::CMR_OP_RFI);
	endproperty
	a_gie: assert property (p_gie)
		else $error("global enable set at wrong time");

	property p_retlit_acc;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_RETLIT |=>
			o_acc == $past(i_instr[7:0]) && !o_irq_ctrl_set;
	endproperty
	a_retlit_acc: assert property (p_retlit_acc)
		else $error("return literal accumulator wrong");

	property p_retlit_pc;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_RETLIT |=>
			o_pc == $past(i_top_of_stack) && o_stack_pop
			##0 s_flush_then_ready ##0 o_pc == $past(o_pc);
	endproperty
	a_retlit_pc: assert property (p_retlit_pc)
		else $error("return literal counter wrong");

	property p_nop;
		@(posedge i_clk) disable iff (i_rst)
		take && dec_op == cmr_pkg::CMR_OP_NOP |=>
			(o_acc == $past(o_acc) && !o_file_we && !o_irq_ctrl_set) and
			s_single_step;
	endproperty
	a_nop: assert property (p_nop)
		else $error("no-op changed state");

	// A word offered in the dead slot must leave no trace
	property p_flush_ignore;
		@(posedge i_clk) disable iff (i_rst)
		!o_ready |=> o_ready && o_pc == $past(o_pc) &&
			o_acc == $past(o_acc) && !o_stack_pop && !o_file_we &&
			!o_unsupported;
	endproperty
	a_flush_ignore: assert property (p_flush_ignore)
		else $error("word accepted during return dead slot");
endmodule

// ===== sim/cmr_core_tb.sv
`timescale 1ns/1ps
module cmr_core_tb;
	logic i_clk, i_rst, i_instr_valid;
	logic [13:0] i_instr;
	logic [12:0] i_top_of_stack;
	logic o_ready, o_stack_pop, o_file_we, o_irq_ctrl_set, o_unsupported;
	logic [12:0] o_pc;
	logic [7:0] o_acc, o_file_wdata, o_irq_ctrl_mask;
	logic [6:0] o_file_addr;
	logic [12:0] m_pc;
	logic [7:0] m_acc, m_wd;
	logic [6:0] m_fa;
	logic m_fl;
	logic [31:0] r;
	integer failures = 0, n_tests = 0, seed = 32'hCD4495AB, i;

	cmr_core #(.PC_W(13)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_instr(i_instr), .i_instr_valid(i_instr_valid),
		.o_ready(o_ready), .i_top_of_stack(i_top_of_stack),
		.o_stack_pop(o_stack_pop), .o_pc(o_pc), .o_acc(o_acc),
		.o_file_we(o_file_we), .o_file_addr(o_file_addr),
		.o_file_wdata(o_file_wdata), .o_irq_ctrl_set(o_irq_ctrl_set),
		.o_irq_ctrl_mask(o_irq_ctrl_mask), .o_unsupported(o_unsupported));

	// Free-running 40 MHz clock
	initial begin
		i_clk = 0;
		forever #12.5 i_clk = ~i_clk;
	end

	task check(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Random word of one of the six kinds; don't-care bits vary too
	function logic [13:0] gen(input logic [31:0] v);
		case (v[2:0] % 6)
			0: gen = {7'h01, v[12:6]};
			1: gen = {4'hC, v[15:14], v[13:6]};
			2: gen = {7'h00, v[15:14], 5'h00};
			3: gen = 14'h0009;
			4: gen = {4'hD, v[15:14], v[13:6]};
			default: gen = {6'h01, v[13:6]};
		endcase
	endfunction

	// Present one word at the falling edge, check effects one cycle later
	task step(input logic [13:0] w, input logic v, input logic [12:0] t);
		logic we, pop, st, un;
		begin
			i_instr = w;
			i_instr_valid = v;
			i_top_of_stack = t;
			{we, pop, st, un} = 4'h0;
			check("ready", o_ready, !m_fl);
			if (m_fl) begin
				m_fl = 0;
			end else if (v) begin
				m_pc = m_pc + 13'h0001;
				if ((w & 14'h3F80) == 14'h0080) begin
					we = 1;
					m_fa = w[6:0];
					m_wd = m_acc;
				end else if (w == 14'h0009) begin
					m_pc = t;
					{pop, st, m_fl} = 3'h7;
				end else if ((w & 14'h3C00) == 14'h3000) begin
					m_acc = w[7:0];
				end else if ((w & 14'h3C00) == 14'h3400) begin
					m_acc = w[7:0];
					m_pc = t;
					{pop, m_fl} = 2'h3;
				end else if ((w & 14'h3F9F) != 14'h0000) begin
					un = 1;
				end
			end
			@(negedge i_clk);
			check("pc", o_pc, m_pc);
			check("acc", o_acc, m_acc);
			check("we", o_file_we, we);
			check("faddr", o_file_addr, m_fa);
			check("wdata", o_file_wdata, m_wd);
			check("pop", o_stack_pop, pop);
			check("gie", o_irq_ctrl_set, st);
			check("mask", o_irq_ctrl_mask, st ? 8'h80 : 8'h00);
			check("unsup", o_unsupported, un);
		end
	endtask

	// Reset held for 12 cycles with a request pending all the while
	task do_reset;
		i_rst = 1;
		repeat (12) @(negedge i_clk);
		i_rst = 0;
		{m_pc, m_acc, m_fa, m_wd, m_fl} = 37'h0;
		check("pc", o_pc, 13'h0000);
		check("acc", o_acc, 8'h00);
	endtask

	// Main sequence: corners, random traffic, reset in mid-return
	initial begin
		i_rst = 1;
		i_instr_valid = 1;
		i_instr = 14'h3055;
		i_top_of_stack = 13'h1ABC;
		do_reset;
		step(14'h30FF, 1, 13'h0000);
		step(14'h00FF, 1, 13'h0000);
		step(14'h0080, 1, 13'h0000);
		step(14'h3300, 1, 13'h0000);
		step(14'h0009, 1, 13'h1FFF);
		step(14'h3401, 1, 13'h0000);
		step(14'h3401, 1, 13'h0000);
		step(14'h0009, 1, 13'h0123);
		step(14'h0060, 1, 13'h0000);
		step(14'h0000, 0, 13'h0000);
		step(14'h3FFF, 1, 13'h0000);
		$display("corner cases done");
		for (i = 0; i < 2000; i++) begin
			r = $random(seed);
			step(gen(r), r[20] | r[21], r[28:16]);
		end
		$display("random traffic done");
		step(14'h0009, 1, 13'h0AAA);
		do_reset;
		step(14'h3042, 1, 13'h0000);
		$display("mid-run reset done");
		conclude;
	end

	// Watchdog well beyond the expected run of about 2040 cycles
	initial begin
		#200000;
		failures++;
		conclude;
	end
endmodule
